// File: rtl/power_rail_sequencer.sv
// Power rail sequencer: ordered rail and pin enable at up and down.
// Assumes synchronous inputs on i_core_clk and a strobe register port.
// Function
// - Sequencing is in use when any rail or pin is assigned to it.
// - Switching rails run either in sequence mode or individual mode.
// - Linear rails support sequence, individual or always-on mode.
// - Power-up starts on supply release below thermal shutdown or recovery.
// - Sequence rails enable at points a,b,c,d, one step delay apart.
// - Step delay programmable from 1 ms to 64 ms.
// - Sequencer pins go high at their assigned power-up point.
// - After good check delay past d, flag set if all sequence rails good.
// - Without sequencing, individual requests are served at once.
// - Power-down starts on storage shutdown, power cycle or pulldown mode.
// - Power-down clears the rails good flag at once.
// - One step later, sequence rails disable in order d,c,b,a.
// - Sequencer pins go low at their assigned power-down point.
// - Individual rails still enabled are disabled together at point d.
// - One step after a, open both switches, then pull system rail low.
// - Without sequencing, power-down still runs d, a, switches, pulldown.
`timescale 1ns/100ps
module power_rail_sequencer #(
    parameter int TICK_CYCLES = power_seq_pkg::TICK_CYCLES
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    input  wire logic        i_sys_above_release,
    input  wire logic        i_thermal_shutdown_event,
    input  wire logic        i_storage_shutdown,
    input  wire logic        i_hard_power_cycle,
    input  wire logic [3:0]  i_rail_good,
    input  wire logic [3:0]  i_rail_uvlo_ok,
    input  wire logic [3:0]  i_rail_pin_en,
    output logic      [3:0]  o_rail_en,
    output logic      [3:0]  o_seq_pin,
    output logic      [3:0]  o_seq_pin_oe,
    output logic             o_input_switch_on,
    output logic             o_battery_switch_on,
    output logic             o_sys_pulldown,
    output logic             o_rails_good_flag,
    output logic             o_irq
);
    typedef enum logic [7:0] {
        ST_OFF   = 8'h01,
        ST_UP    = 8'h02,
        ST_CHECK = 8'h04,
        ST_ON    = 8'h08,
        ST_DOWN  = 8'h10,
        ST_SWOFF = 8'h20,
        ST_PULL  = 8'h40,
        ST_IDLE  = 8'h80
    } seq_state_e;

    // Point field per slot: 2 bits, slots 0..3 rails, 4..7 pins.
    function automatic logic [1:0] slot_point(input logic [15:0] pts,
                                              input int idx);
        slot_point = pts[idx*2 +: 2];
    endfunction : slot_point

    seq_state_e  state_reg;
    logic [7:0]  rail_cfg_reg;
    logic [3:0]  pin_cfg_reg;
    logic [15:0] slot_pt_reg;
    logic [31:0] ctrl_reg;
    logic [3:0]  indiv_en_reg;
    logic [2:0]  irq_stat_reg;
    logic [2:0]  irq_mask_reg;
    logic [16:0] tick_cnt_reg;
    logic        tick;
    logic [6:0]  ms_cnt_reg;
    logic [2:0]  point_reg;
    logic        prev_release_reg;
    logic        prev_thermal_shutdown_event_reg;
    logic [3:0]  rail_seq;
    logic [3:0]  rail_on_mode;
    logic        seq_used;
    logic        up_start;
    logic        down_req;
    logic [6:0]  step_ms;
    logic        step_done;
    logic [2:0]  irq_set;
    logic [1:0]  system_rail_mode;
    logic [3:0]  seq_en_mask;
    logic [3:0]  pin_level;
    logic        indiv_allowed;
    logic        timer_restart;

    assign system_rail_mode = ctrl_reg[power_seq_pkg::CTRL_SYSMODE_LSB +: 2];
    // A field value of 0..63 maps to 1..64 ms.
    assign step_ms = {1'b0, ctrl_reg[power_seq_pkg::CTRL_DELAY_LSB +:
                     power_seq_pkg::CTRL_DELAY_W]} + 7'h01;

    genvar gi;
    generate
        for (gi = 0; gi < power_seq_pkg::NRAIL; gi++) begin : g_mode
            assign rail_seq[gi] =
                rail_cfg_reg[gi*2 +: 2] == power_seq_pkg::MODE_SEQ;
            // Only the linear rails (2 and 3) honour always-on.
            assign rail_on_mode[gi] = (gi >= 2) &&
                rail_cfg_reg[gi*2 +: 2] == power_seq_pkg::MODE_ON;
        end
    endgenerate

    assign seq_used = (|rail_seq) || (|pin_cfg_reg);
    assign up_start = seq_used && !i_thermal_shutdown_event &&
        i_sys_above_release &&
        (!prev_release_reg || prev_thermal_shutdown_event_reg);
    assign down_req = i_storage_shutdown || i_hard_power_cycle ||
        system_rail_mode == power_seq_pkg::SYS_PULLDOWN;
    assign timer_restart = (state_reg == ST_OFF && up_start) || (down_req &&
        state_reg inside {ST_OFF, ST_IDLE, ST_ON, ST_UP, ST_CHECK});

    // Millisecond tick, restarted at a sequence start so no step runs short.
    always_ff @(posedge i_core_clk) begin
        if (i_rst || timer_restart ||
            tick_cnt_reg == 17'(TICK_CYCLES - 1)) begin
            tick_cnt_reg <= '0;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + 17'h00001;
        end
    end
    assign tick = tick_cnt_reg == 17'(TICK_CYCLES - 1);
    assign step_done = tick && (ms_cnt_reg + 7'h01 >=
        ((state_reg == ST_CHECK) ?
        7'(power_seq_pkg::GOOD_CHECK_MS) : step_ms));

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            prev_release_reg <= 1'b0;
            prev_thermal_shutdown_event_reg   <= 1'b0;
        end else begin
            prev_release_reg <= i_sys_above_release;
            prev_thermal_shutdown_event_reg   <= i_thermal_shutdown_event;
        end
    end

    // Sequencer state; point_reg counts points reached (0 = none yet).
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            state_reg  <= ST_OFF;
            point_reg  <= 3'h0;
            ms_cnt_reg <= 7'h00;
        end else begin
            if (tick) begin
                ms_cnt_reg <= step_done ? 7'h00 : ms_cnt_reg + 7'h01;
            end
            case (state_reg)
                ST_OFF, ST_IDLE, ST_ON: begin
                    if (down_req) begin
                        state_reg  <= ST_DOWN;
                        point_reg  <= 3'h4;
                        ms_cnt_reg <= 7'h00;
                    end else if (up_start && state_reg == ST_OFF) begin
                        state_reg  <= ST_UP;
                        point_reg  <= 3'h0;
                        ms_cnt_reg <= 7'h00;
                    end else if (state_reg == ST_OFF && !seq_used &&
                                 i_sys_above_release) begin
                        state_reg <= ST_IDLE;
                    end else if (state_reg == ST_IDLE && seq_used) begin
                        state_reg <= ST_OFF;
                    end
                end
                ST_UP: begin
                    if (down_req) begin
                        state_reg  <= ST_DOWN;
                        ms_cnt_reg <= 7'h00;
                    end else if (step_done) begin
                        point_reg <= point_reg + 3'h1;
                        if (point_reg == 3'h3) begin
                            state_reg <= ST_CHECK;
                        end
                    end
                end
                ST_CHECK: begin
                    if (down_req) begin
                        state_reg  <= ST_DOWN;
                        ms_cnt_reg <= 7'h00;
                    end else if (step_done) begin
                        state_reg <= ST_ON;
                    end
                end
                ST_DOWN: begin
                    if (step_done) begin
                        // Point d is reached after one step; a after four.
                        if (point_reg == 3'h0) begin
                            state_reg <= ST_SWOFF;
                        end else begin
                            point_reg <= point_reg - 3'h1;
                        end
                    end
                end
                ST_SWOFF: begin
                    state_reg <= ST_PULL;
                end
                ST_PULL: begin
                    if (!down_req) begin
                        state_reg <= ST_OFF;
                    end
                end
                default: state_reg <= ST_OFF;
            endcase
        end
    end

    // Slot is on when its point (0=a..3=d) lies below point_reg.
    generate
        for (gi = 0; gi < power_seq_pkg::NRAIL; gi++) begin : g_slot
            assign seq_en_mask[gi] = rail_seq[gi] &&
                {1'b0, slot_point(slot_pt_reg, gi)} < point_reg;
            assign pin_level[gi] = pin_cfg_reg[gi] &&
                {1'b0, slot_point(slot_pt_reg, gi + 4)} <
                point_reg;
        end
    endgenerate

    // Power-down counts point_reg 4..0, so d drops at the first step.
    assign indiv_allowed = (state_reg == ST_IDLE) || (state_reg == ST_ON) ||
        (state_reg == ST_DOWN && point_reg == 3'h4);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rail_en    <= 4'h0;
            o_seq_pin    <= 4'h0;
            o_seq_pin_oe <= 4'h0;
        end else begin
            for (int i = 0; i < power_seq_pkg::NRAIL; i++) begin
                if (rail_seq[i]) begin
                    o_rail_en[i] <= seq_en_mask[i];
                end else if (rail_on_mode[i]) begin
                    o_rail_en[i] <= state_reg != ST_SWOFF &&
                        state_reg != ST_PULL;
                end else begin
                    o_rail_en[i] <= indiv_allowed && i_rail_uvlo_ok[i] &&
                        (indiv_en_reg[i] || i_rail_pin_en[i]);
                end
            end
            o_seq_pin    <= pin_level;
            o_seq_pin_oe <= pin_cfg_reg;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_input_switch_on   <= 1'b0;
            o_battery_switch_on <= 1'b0;
            o_sys_pulldown      <= 1'b0;
        end else begin
            o_input_switch_on   <= state_reg != ST_SWOFF &&
                state_reg != ST_PULL;
            o_battery_switch_on <= state_reg != ST_SWOFF &&
                state_reg != ST_PULL;
            o_sys_pulldown      <= state_reg == ST_PULL;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst || down_req) begin
            o_rails_good_flag <= 1'b0;
        end else if (state_reg == ST_CHECK && step_done) begin
            o_rails_good_flag <= &(i_rail_good | ~rail_seq);
        end
    end

    assign irq_set[power_seq_pkg::IRQ_UP_DONE] =
        state_reg == ST_UP && step_done && point_reg == 3'h3;
    assign irq_set[power_seq_pkg::IRQ_GOOD] = state_reg == ST_CHECK &&
        step_done && !down_req && &(i_rail_good | ~rail_seq);
    assign irq_set[power_seq_pkg::IRQ_DOWN_DONE] = state_reg == ST_SWOFF;

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            irq_stat_reg <= 3'h0;
        end else if (i_wr && i_addr == power_seq_pkg::REG_IRQ_STAT) begin
            irq_stat_reg <= (irq_stat_reg & ~i_wdata[2:0]) | irq_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_set;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |((irq_stat_reg | irq_set) & irq_mask_reg);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            rail_cfg_reg <= 8'h00;
            pin_cfg_reg  <= 4'h0;
            slot_pt_reg  <= 16'h0000;
            ctrl_reg     <= power_seq_pkg::CTRL_RESET;
            irq_mask_reg <= 3'h0;
            indiv_en_reg <= 4'h0;
        end else if (i_wr) begin
            case (i_addr)
                power_seq_pkg::REG_RAIL_CFG: rail_cfg_reg <= i_wdata[7:0];
                power_seq_pkg::REG_PIN_CFG:  pin_cfg_reg  <= i_wdata[3:0];
                power_seq_pkg::REG_SLOT_PT:  slot_pt_reg  <= i_wdata[15:0];
                power_seq_pkg::REG_CTRL:     ctrl_reg     <= i_wdata;
                power_seq_pkg::REG_IRQ_MASK: irq_mask_reg <= i_wdata[2:0];
                power_seq_pkg::REG_INDIV_EN: indiv_en_reg <= i_wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                power_seq_pkg::REG_RAIL_CFG: o_rdata <= {24'h0, rail_cfg_reg};
                power_seq_pkg::REG_PIN_CFG:  o_rdata <= {28'h0, pin_cfg_reg};
                power_seq_pkg::REG_SLOT_PT:  o_rdata <= {16'h0, slot_pt_reg};
                power_seq_pkg::REG_CTRL:     o_rdata <= ctrl_reg;
                power_seq_pkg::REG_STATUS:   o_rdata <= {15'h0, seq_used,
                    state_reg, point_reg, o_rails_good_flag, o_rail_en};
                power_seq_pkg::REG_IRQ_STAT: o_rdata <= {29'h0, irq_stat_reg};
                power_seq_pkg::REG_IRQ_MASK: o_rdata <= {29'h0, irq_mask_reg};
                power_seq_pkg::REG_INDIV_EN: o_rdata <= {28'h0, indiv_en_reg};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // Checks.
    property p_good_clear;
        @(posedge i_core_clk) disable iff (i_rst)
        down_req |=> !o_rails_good_flag;
    endproperty
    a_good_clear: assert property (p_good_clear)
        else $error("good flag not cleared on power-down");

    property p_use;
        @(posedge i_core_clk) disable iff (i_rst)
        (state_reg == ST_OFF && !seq_used && !down_req) |=> state_reg != ST_UP;
    endproperty
    a_use: assert property (p_use)
        else $error("sequence started while unused");

    property p_pull_after_sw;
        @(posedge i_core_clk) disable iff (i_rst)
        state_reg == ST_SWOFF |=> ##1 o_sys_pulldown && !o_input_switch_on;
    endproperty
    a_pull_after_sw: assert property (p_pull_after_sw)
        else $error("system rail not pulled after switches off");

    property p_up_order;
        @(posedge i_core_clk) disable iff (i_rst)
        (state_reg == ST_UP && !step_done && !down_req) |=>
            $stable(point_reg);
    endproperty
    a_up_order: assert property (p_up_order)
        else $error("point advanced without a step");

    property p_down_order;
        @(posedge i_core_clk) disable iff (i_rst)
        (state_reg == ST_DOWN && step_done && point_reg != 3'h0) |=>
            point_reg == $past(point_reg) - 3'h1;
    endproperty
    a_down_order: assert property (p_down_order)
        else $error("power-down point out of order");

    property p_delay_range;
        @(posedge i_core_clk) disable iff (i_rst)
        step_ms >= 7'h01 && step_ms <= 7'h40;
    endproperty
    a_delay_range: assert property (p_delay_range)
        else $error("step delay out of range");

    property p_indiv_off;
        @(posedge i_core_clk) disable iff (i_rst)
        (state_reg == ST_DOWN && point_reg != 3'h4) |=>
            ((o_rail_en & ~rail_seq & ~rail_on_mode) == 4'h0);
    endproperty
    a_indiv_off: assert property (p_indiv_off)
        else $error("individual rail still on after point d");

    property p_pin_oe;
        @(posedge i_core_clk) disable iff (i_rst)
        ##1 ((o_seq_pin & ~o_seq_pin_oe) == 4'h0);
    endproperty
    a_pin_oe: assert property (p_pin_oe)
        else $error("sequencer pin driven high while not an output");
endmodule : power_rail_sequencer

// File: shared/power_seq_pkg.sv
// Constants for the power rail sequencer: register map, fields, timing.
// Assumes a 100 MHz core clock and a plain strobe register port.
package power_seq_pkg;
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int TICK_W = 17;
    localparam int GOOD_CHECK_MS = 2;
    localparam int NRAIL = 4;
    localparam int NPIN = 4;
    localparam int NSLOT = NRAIL + NPIN;
    // Register offsets.
    localparam logic [3:0] REG_RAIL_CFG = 4'h0;
    localparam logic [3:0] REG_PIN_CFG = 4'h1;
    localparam logic [3:0] REG_SLOT_PT = 4'h2;
    localparam logic [3:0] REG_CTRL = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_IRQ_STAT = 4'h5;
    localparam logic [3:0] REG_IRQ_MASK = 4'h6;
    localparam logic [3:0] REG_INDIV_EN = 4'h7;
    // Rail mode encodings, two bits per rail.
    localparam logic [1:0] MODE_INDIV = 2'h0;
    localparam logic [1:0] MODE_SEQ = 2'h1;
    localparam logic [1:0] MODE_ON = 2'h2;
    // Control register fields.
    localparam int CTRL_DELAY_LSB = 0;
    localparam int CTRL_DELAY_W = 6;
    localparam int CTRL_SYSMODE_LSB = 8;
    localparam logic [1:0] SYS_PULLDOWN = 2'h3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // Interrupt bits.
    localparam int IRQ_UP_DONE = 0;
    localparam int IRQ_GOOD = 1;
    localparam int IRQ_DOWN_DONE = 2;
    localparam int NIRQ = 3;
endpackage : power_seq_pkg

// File: tb/rail_load_model.sv
// Behavioural model of the rails and external loads behind the sequencer.
// Assumes rail enables registered on i_core_clk; rails ramp before good.
`timescale 1ns/100ps
module rail_load_model #(
    parameter int RAMP = 20
) (
    input  wire logic       i_core_clk,
    input  wire logic [3:0] i_rail_en,
    input  wire logic       i_sys_ok,
    output logic      [3:0] o_rail_good,
    output logic      [3:0] o_rail_uvlo_ok
);
    int ramp_cnt [4];

    // A rail reports good only after ramping, so an early check would fail.
    always_ff @(posedge i_core_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!i_rail_en[i]) begin
                ramp_cnt[i] <= 0;
            end else if (ramp_cnt[i] < RAMP) begin
                ramp_cnt[i] <= ramp_cnt[i] + 1;
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            o_rail_good[i] = (ramp_cnt[i] >= RAMP);
        end
    end

    assign o_rail_uvlo_ok = {4{i_sys_ok}};
endmodule : rail_load_model

// File: tb/power_rail_sequencer_tb_top.sv
// Testbench of the power rail sequencer: registers, sequences, interrupt.
// Assumes the strobe register port; the tick is shortened to keep runs short.
`timescale 1ns/100ps
`define CHECK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
    bad_count++; $display("Error %s expected %0h seen %0h", nm, exp, got); \
    end end
module power_rail_sequencer_tb_top;
    localparam int STEP  = 100;
    localparam int LIMIT = 6 * STEP;
    logic        i_thermal_shutdown_event;
    logic        i_hard_power_cycle;
    logic [3:0]  i_rail_pin_en;
    logic        i_core_clk;
    logic        i_rst;
    logic [3:0]  i_addr;
    logic [31:0] i_wdata;
    logic        i_wr;
    logic        i_rd;
    logic [31:0] o_rdata;
    logic        i_sys_above_release;
    logic [3:0]  i_rail_good;
    logic [3:0]  i_rail_uvlo_ok;
    logic [3:0]  o_rail_en;
    logic [3:0]  o_seq_pin;
    logic [3:0]  o_seq_pin_oe;
    logic        o_input_switch_on;
    logic        o_battery_switch_on;
    logic        o_sys_pulldown;
    logic        o_rails_good_flag;
    logic        o_irq;
    logic [31:0] rd_val;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    int          t_start;
    int          t_sw;
    int          t_pt [4];
    int          rail_pt [4] = '{3, 2, 1, 0};
    int          pin_pt [2] = '{0, 3};

    power_rail_sequencer #(.TICK_CYCLES(STEP)) dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_sys_above_release(i_sys_above_release),
        .i_thermal_shutdown_event(i_thermal_shutdown_event),
        .i_storage_shutdown(1'b0),
        .i_hard_power_cycle(i_hard_power_cycle), .i_rail_good(i_rail_good),
        .i_rail_uvlo_ok(i_rail_uvlo_ok), .i_rail_pin_en(i_rail_pin_en),
        .o_rail_en(o_rail_en), .o_seq_pin(o_seq_pin),
        .o_seq_pin_oe(o_seq_pin_oe), .o_input_switch_on(o_input_switch_on),
        .o_battery_switch_on(o_battery_switch_on),
        .o_sys_pulldown(o_sys_pulldown),
        .o_rails_good_flag(o_rails_good_flag), .o_irq(o_irq)
    );

    rail_load_model #(.RAMP(20)) load (
        .i_core_clk(i_core_clk), .i_rail_en(o_rail_en),
        .i_sys_ok(i_sys_above_release), .o_rail_good(i_rail_good),
        .o_rail_uvlo_ok(i_rail_uvlo_ok)
    );

    initial begin
        i_core_clk = 1'b0;
        forever #5 i_core_clk = ~i_core_clk;
    end

    always @(posedge i_core_clk) cyc <= cyc + 1;

    function automatic logic [3:0] rails_below(input int th);
        logic [3:0] r;
        for (int i = 0; i < 4; i++) r[i] = (rail_pt[i] < th);
        return r;
    endfunction : rails_below

    function automatic logic [3:0] pins_below(input int th);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 2; i++) r[i] = (pin_pt[i] < th);
        return r;
    endfunction : pins_below

    function automatic logic [3:0] probe(input int sel);
        case (sel)
            0: return o_rail_en;
            1: return {3'h0, o_rails_good_flag};
            default: return {3'h0, o_input_switch_on};
        endcase
    endfunction : probe

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_core_clk);
        i_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        @(posedge i_core_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_core_clk);
        i_rd   <= 1'b0;
        #1;
        rd_val = o_rdata;
    endtask : rd

    // Bounded so that a stuck sequence shows as a mismatch, not a hang.
    task automatic wait_on(input int sel, input logic [3:0] exp,
                           output int t);
        int n;
        n = 0;
        while (probe(sel) !== exp && n < LIMIT) begin
            @(negedge i_core_clk);
            n++;
        end
        if (probe(sel) !== exp) bad_count++;
        t = cyc;
    endtask : wait_on

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (40 * STEP) @(posedge i_core_clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        i_rst = 1'b1;
        i_addr = 4'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_sys_above_release = 1'b1;
        i_thermal_shutdown_event = 1'b0;
        i_hard_power_cycle = 1'b0;
        i_rail_pin_en = 4'h0;
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        rd(power_seq_pkg::REG_CTRL);
        `CHECK("ctrl", power_seq_pkg::CTRL_RESET, rd_val)
        rd(4'hf);
        `CHECK("unmapped", 32'h0, rd_val)
        rd(power_seq_pkg::REG_STATUS);
        `CHECK("seq_used", 1'b0, rd_val[16])
        wr(power_seq_pkg::REG_INDIV_EN, 32'h5);
        repeat (4) @(negedge i_core_clk);
        `CHECK("indiv on", 4'h5, o_rail_en)
        wr(power_seq_pkg::REG_CTRL, 32'h300);
        t_start = cyc;
        wait_on(0, 4'h0, t_pt[0]);
        `CHECK("indiv at d", 1'b1, t_pt[0] - t_start >= STEP &&
               t_pt[0] - t_start <= STEP + 3)
        wait_on(2, 4'h0, t_sw);
        `CHECK("no seq switches", 1'b1, t_sw - t_pt[0] >= 4 * STEP - 2 &&
               t_sw - t_pt[0] <= 4 * STEP + 2)
        wr(power_seq_pkg::REG_CTRL, 32'h0);
        repeat (4) @(negedge i_core_clk);
        wr(power_seq_pkg::REG_INDIV_EN, 32'h0);
        repeat (4) @(negedge i_core_clk);
        `CHECK("indiv off", 4'h0, o_rail_en)
        @(posedge i_core_clk);
        i_rail_pin_en <= 4'ha;
        repeat (4) @(negedge i_core_clk);
        `CHECK("pin on", 4'ha, o_rail_en)
        @(posedge i_core_clk);
        i_rail_pin_en <= 4'h0;
        $display("test individual done");
        i_sys_above_release <= 1'b0;
        wr(power_seq_pkg::REG_RAIL_CFG, 32'h55);
        wr(power_seq_pkg::REG_PIN_CFG, 32'h3);
        wr(power_seq_pkg::REG_SLOT_PT, 32'hc1b);
        wr(power_seq_pkg::REG_IRQ_MASK, 32'h3);
        rd(power_seq_pkg::REG_STATUS);
        `CHECK("seq_used", 1'b1, rd_val[16])
        `CHECK("pin oe", 4'h3, o_seq_pin_oe)
        @(posedge i_core_clk);
        i_sys_above_release <= 1'b1;
        t_start = cyc;
        for (int p = 0; p < 4; p++) begin
            wait_on(0, rails_below(p + 1), t_pt[p]);
            `CHECK("up rails", rails_below(p + 1), o_rail_en)
            `CHECK("up pins", pins_below(p + 1), o_seq_pin)
            if (p > 0) `CHECK("up step", STEP, t_pt[p] - t_pt[p-1])
        end
        `CHECK("up start", 1'b1, t_pt[0] - t_start >= STEP &&
               t_pt[0] - t_start <= 2 * STEP + 2)
        wait_on(1, 4'h1, t_sw);
        `CHECK("good delay", 1'b1, t_sw - t_pt[3] >= 2 * STEP - 2 &&
               t_sw - t_pt[3] <= 2 * STEP + 2)
        `CHECK("good", 1'b1, o_rails_good_flag)
        repeat (3) @(negedge i_core_clk);
        `CHECK("irq up", 1'b1, o_irq)
        rd(power_seq_pkg::REG_IRQ_STAT);
        `CHECK("irq stat", 2'h3, rd_val[1:0])
        wr(power_seq_pkg::REG_IRQ_STAT, 32'h7);
        repeat (3) @(negedge i_core_clk);
        `CHECK("irq cleared", 1'b0, o_irq)
        $display("test power up done");
        wr(power_seq_pkg::REG_CTRL, 32'h300);
        repeat (2) @(negedge i_core_clk);
        t_start = cyc;
        `CHECK("good cleared", 1'b0, o_rails_good_flag)
        `CHECK("rails held", 4'hf, o_rail_en)
        for (int k = 0; k < 4; k++) begin
            wait_on(0, rails_below(3 - k), t_pt[k]);
            `CHECK("down rails", rails_below(3 - k), o_rail_en)
            `CHECK("down pins", pins_below(3 - k), o_seq_pin)
            if (k > 0) `CHECK("down step", STEP, t_pt[k] - t_pt[k-1])
        end
        `CHECK("down start", 1'b1, t_pt[0] - t_start >= STEP - 2 &&
               t_pt[0] - t_start <= 2 * STEP + 2)
        wait_on(2, 4'h0, t_sw);
        `CHECK("switch delay", 1'b1, t_sw - t_pt[3] >= STEP - 2 &&
               t_sw - t_pt[3] <= STEP + 2)
        `CHECK("battery switch", 1'b0, o_battery_switch_on)
        `CHECK("pulldown late", 1'b0, o_sys_pulldown)
        repeat (3) @(negedge i_core_clk);
        `CHECK("pulldown", 1'b1, o_sys_pulldown)
        `CHECK("rails stay off", 4'h0, o_rail_en)
        rd(power_seq_pkg::REG_IRQ_STAT);
        `CHECK("down stat", 1'b1, rd_val[2])
        `CHECK("irq masked", 1'b0, o_irq)
        wr(power_seq_pkg::REG_IRQ_MASK, 32'h4);
        repeat (3) @(negedge i_core_clk);
        `CHECK("irq unmasked", 1'b1, o_irq)
        wr(power_seq_pkg::REG_IRQ_STAT, 32'h4);
        repeat (3) @(negedge i_core_clk);
        `CHECK("irq down cleared", 1'b0, o_irq)
        wr(power_seq_pkg::REG_CTRL, 32'h0);
        repeat (4) @(negedge i_core_clk);
        `CHECK("pulldown released", 1'b0, o_sys_pulldown)
        $display("test power down done");
        @(posedge i_core_clk);
        i_thermal_shutdown_event <= 1'b1;
        @(posedge i_core_clk);
        i_thermal_shutdown_event <= 1'b0;
        wait_on(0, rails_below(1), t_pt[0]);
        `CHECK("recovery up", rails_below(1), o_rail_en)
        @(posedge i_core_clk);
        i_hard_power_cycle <= 1'b1;
        wait_on(0, 4'h0, t_sw);
        `CHECK("power cycle", 4'h0, o_rail_en)
        $display("test recovery done");
        report_and_stop();
    end
endmodule : power_rail_sequencer_tb_top
